// ---- mob_override.sv ----
`timescale 1ns/1ns
`default_nettype none

module mob_override #(
  parameter int RAMP_W  = 8,
  parameter int FAULT_W = 8
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire mob_pkg::mob_reg_req_t i_req,
  input  wire mob_pkg::mob_cfg_t    i_cfg,
  input  wire logic                 i_pwr_req,
  input  wire logic                 i_ac_sense,
  input  wire logic [RAMP_W-1:0]    i_ramp,
  input  wire logic [RAMP_W-1:0]    i_ramp_final,
  input  wire logic [FAULT_W-1:0]   i_fault_now,
  output logic [7:0]                o_rd_data,
  output logic                      o_pwr_to_debounce,
  output logic                      o_ac_good_function,
  output logic                      o_ac_good_report,
  output logic                      o_power_enable_gate,
  output logic                      o_clamp_release,
  output logic                      o_fault_pin,
  output logic                      o_alert_o,
  output logic                      o_alert_oe_n
);
  import mob_pkg::*;

  localparam int PW = RAMP_W + 8;

  logic               pwr_ovr_q;
  logic               ac_ovr_q;
  logic               clmp_ovr_q;
  logic               alrt_ovr_q;
  logic               alrt_own_q;
  logic               pend_pwr_q;
  logic               pend_ac_q;
  logic               pend_clmp_q;
  logic               pend_alrt_q;
  logic               pend_pa_q;
  logic               pend_c_q;
  logic               pend_a_q;
  logic [FAULT_W-1:0] flt_prev_q;
  logic [FAULT_W-1:0] flt_lat_q;
  logic [FAULT_W-1:0] flt_lat_d;
  logic [FAULT_W-1:0] flt_rise;
  logic               flt_rd;
  logic               pwr_int;
  logic               ac_int;
  logic               ramp_hit;
  logic [PW-1:0]      ramp_pct;
  logic [PW-1:0]      thr_pct;

  // Stage written bytes until the transaction closes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_pwr_q  <= MOB_RST_BIT;
      pend_ac_q   <= MOB_RST_BIT;
      pend_clmp_q <= MOB_RST_BIT;
      pend_alrt_q <= MOB_RST_BIT;
      pend_pa_q   <= MOB_RST_BIT;
      pend_c_q    <= MOB_RST_BIT;
      pend_a_q    <= MOB_RST_BIT;
    end else if (i_req.commit) begin
      pend_pa_q <= 1'b0;
      pend_c_q  <= 1'b0;
      pend_a_q  <= 1'b0;
    end else if (i_req.wr) begin
      unique case (i_req.addr)
        MOB_OFS_PWR_AC: begin
          pend_pwr_q <= i_req.data[MOB_BIT_PWR_OVR];
          pend_ac_q  <= i_req.data[MOB_BIT_AC_OVR];
          pend_pa_q  <= 1'b1;
        end
        MOB_OFS_CLAMP: begin
          pend_clmp_q <= i_req.data[MOB_BIT_CLMP_OVR];
          pend_c_q    <= 1'b1;
        end
        MOB_OFS_ALERT: begin
          pend_alrt_q <= i_req.data[MOB_BIT_ALRT_OVR];
          pend_a_q    <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Commit overrides at transaction end; held until rewritten
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_ovr_q  <= MOB_RST_BIT;
      ac_ovr_q   <= MOB_RST_BIT;
      clmp_ovr_q <= MOB_RST_BIT;
      alrt_ovr_q <= MOB_RST_BIT;
      alrt_own_q <= MOB_RST_BIT;
    end else if (i_req.commit) begin
      if (pend_pa_q) begin
        pwr_ovr_q <= pend_pwr_q;
        ac_ovr_q  <= pend_ac_q;
      end
      if (pend_c_q) begin
        clmp_ovr_q <= pend_clmp_q;
      end
      if (pend_a_q) begin
        alrt_ovr_q <= pend_alrt_q;
        alrt_own_q <= 1'b1;
      end
    end
  end

  // Internal function selection
  always_comb begin
    pwr_int = i_cfg.uc_mode ? pwr_ovr_q
                            : (i_cfg.pwr_thru & i_pwr_req);
    ac_int  = i_cfg.uc_mode ? ac_ovr_q
                            : (i_cfg.ac_thru & i_ac_sense);
  end

  // Ramp position against the chosen release point
  always_comb begin
    ramp_pct = PW'(i_ramp) * PW'(100);
    thr_pct  = PW'(i_ramp_final)
             * (i_cfg.clamp_hi ? PW'(MOB_CLAMP_HI_PCT)
                               : PW'(MOB_CLAMP_LO_PCT));
    ramp_hit = (i_ramp_final != '0) && (ramp_pct >= thr_pct);
  end

  // Outputs of the internal functions
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pwr_to_debounce   <= 1'b0;
      o_ac_good_function  <= 1'b0;
      o_ac_good_report    <= 1'b0;
      o_power_enable_gate <= 1'b0;
      o_clamp_release     <= 1'b0;
    end else begin
      o_pwr_to_debounce   <= pwr_int;
      o_ac_good_function  <= ac_int;
      o_ac_good_report    <= ac_int;
      o_power_enable_gate <= ac_int & pwr_int;
      o_clamp_release     <= i_cfg.uc_mode ? clmp_ovr_q
                                           : ramp_hit;
    end
  end

  // Fault latching, rising edges only, cleared on read unless the fault is still present
  always_comb begin
    flt_rise  = i_fault_now & ~flt_prev_q;
    flt_rd    = i_req.rd && (i_req.addr == MOB_OFS_FAULTS);
    flt_lat_d = flt_lat_q;
    if (flt_rd) begin
      flt_lat_d = flt_lat_q & i_fault_now;
    end
    flt_lat_d = flt_lat_d | flt_rise;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flt_prev_q <= '0;
      flt_lat_q  <= '0;
    end else begin
      flt_prev_q <= i_fault_now;
      flt_lat_q  <= flt_lat_d;
    end
  end

  // Alert line and fault pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_alert_o    <= 1'b0;
      o_alert_oe_n <= 1'b1;
      o_fault_pin  <= 1'b0;
    end else begin
      o_alert_o    <= 1'b0;
      o_alert_oe_n <= ~(|flt_lat_d);
      o_fault_pin  <= alrt_own_q ? alrt_ovr_q
                                 : (|flt_lat_d);
    end
  end

  // Read data; write-only registers read zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= MOB_RST_BYTE;
    end else if (i_req.rd) begin
      o_rd_data <= MOB_RST_BYTE;
      if (i_req.addr == MOB_OFS_READBACK) begin
        o_rd_data[MOB_BIT_PWR_RB] <= i_pwr_req;
        o_rd_data[MOB_BIT_AC_RB]  <= i_ac_sense;
      end else if (i_req.addr == MOB_OFS_FAULTS) begin
        o_rd_data <= 8'(flt_lat_q);
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_pa_write;
    i_req.wr && !i_req.commit && i_req.addr == MOB_OFS_PWR_AC;
  endsequence
  sequence s_commit;
    i_req.commit;
  endsequence
  sequence s_clamp_write;
    i_req.wr && !i_req.commit && i_req.addr == MOB_OFS_CLAMP;
  endsequence
  sequence s_alert_write;
    i_req.wr && !i_req.commit && i_req.addr == MOB_OFS_ALERT;
  endsequence

  pwr_readback_a: assert property (
    (i_req.rd && i_req.addr == MOB_OFS_READBACK)
      |=> o_rd_data[MOB_BIT_PWR_RB] == $past(i_pwr_req))
    else $error("power-on readback wrong");
  ac_readback_a: assert property (
    (i_req.rd && i_req.addr == MOB_OFS_READBACK)
      |=> o_rd_data[MOB_BIT_AC_RB] == $past(i_ac_sense))
    else $error("AC readback wrong");
  pwr_commit_a: assert property (
    s_pa_write ##[2:4] s_commit
      |=> pwr_ovr_q == $past(pend_pwr_q))
    else $error("power override not committed");
  pwr_off_a: assert property (
    (i_cfg.uc_mode && !pwr_ovr_q) |=> !o_power_enable_gate)
    else $error("supply on despite zero override");
  ac_override_a: assert property (
    i_cfg.uc_mode |=> o_ac_good_function == $past(ac_ovr_q))
    else $error("AC-good not from override");
  pwr_isolate_a: assert property (
    (!i_cfg.uc_mode && !i_cfg.pwr_thru) |=> !o_pwr_to_debounce)
    else $error("power pin leaked to debounce");
  ac_isolate_a: assert property (
    (!i_cfg.uc_mode && !i_cfg.ac_thru) |=> !o_ac_good_function)
    else $error("AC sense leaked through");
  clamp_ovr_a: assert property (
    i_cfg.uc_mode |=> o_clamp_release == $past(clmp_ovr_q))
    else $error("clamp not from override");
  clamp_ramp_a: assert property (
    (!i_cfg.uc_mode && i_ramp_final != '0)
      |=> o_clamp_release == ($past(ramp_pct) >= $past(thr_pct)))
    else $error("clamp release point wrong");
  fault_pin_a: assert property (
    alrt_own_q |=> o_fault_pin == $past(alrt_ovr_q))
    else $error("fault pin not from override");
  alert_a: assert property (
    (|flt_rise) |=> !o_alert_oe_n && !o_alert_o)
    else $error("alert not raised on fault");
  fault_hold_a: assert property (
    (flt_rd && (|(flt_lat_q & i_fault_now)))
      |=> (|flt_lat_q))
    else $error("present fault cleared by read");

  // Further override, gate, read and alert checks
  clamp_commit_a: assert property (
    s_clamp_write ##[2:4] s_commit
      |=> clmp_ovr_q == $past(pend_clmp_q))
    else $error("clamp override not committed");
  alert_own_a: assert property (
    s_alert_write ##[2:4] s_commit
      |=> alrt_own_q && alrt_ovr_q == $past(pend_alrt_q))
    else $error("fault pin override not taken");
  ovr_hold_a: assert property (
    !i_req.commit
      |=> $stable(pwr_ovr_q) && $stable(ac_ovr_q) && $stable(clmp_ovr_q))
    else $error("override changed without commit");
  ac_report_a: assert property (
    i_cfg.uc_mode |=> o_ac_good_report == $past(ac_ovr_q))
    else $error("AC-good report not from override");
  ac_gate_off_a: assert property (
    (i_cfg.uc_mode && !ac_ovr_q) |=> !o_power_enable_gate)
    else $error("power gate open without AC-good");
  gate_on_a: assert property (
    (i_cfg.uc_mode && ac_ovr_q && pwr_ovr_q) |=> o_power_enable_gate)
    else $error("power gate closed despite overrides");
  wo_read_a: assert property (
    (i_req.rd && (i_req.addr == MOB_OFS_PWR_AC
               || i_req.addr == MOB_OFS_CLAMP
               || i_req.addr == MOB_OFS_ALERT))
      |=> o_rd_data == MOB_RST_BYTE)
    else $error("write-only register read nonzero");
  alert_hold_a: assert property (
    ((|flt_lat_q) && !flt_rd) |=> !o_alert_oe_n)
    else $error("alert dropped while fault latched");
  fault_clear_a: assert property (
    (flt_rd && flt_rise == '0 && (flt_lat_q & i_fault_now) == '0)
      |=> flt_lat_q == '0)
    else $error("fault latch not cleared by read");

endmodule

`default_nettype wire

// ---- mob_pkg.sv ----
package mob_pkg;

  // Register offsets
  localparam logic [7:0] MOB_OFS_READBACK = 8'h02;
  localparam logic [7:0] MOB_OFS_PWR_AC   = 8'h12;
  localparam logic [7:0] MOB_OFS_CLAMP    = 8'h13;
  localparam logic [7:0] MOB_OFS_ALERT    = 8'h1b;
  localparam logic [7:0] MOB_OFS_FAULTS   = 8'h2c;

  // Field positions
  localparam int MOB_BIT_PWR_RB   = 6;
  localparam int MOB_BIT_AC_RB    = 7;
  localparam int MOB_BIT_PWR_OVR  = 1;
  localparam int MOB_BIT_AC_OVR   = 5;
  localparam int MOB_BIT_CLMP_OVR = 2;
  localparam int MOB_BIT_ALRT_OVR = 1;

  // Values after reset
  localparam logic [7:0] MOB_RST_BYTE = 8'h00;
  localparam logic       MOB_RST_BIT  = 1'b0;

  // Clamp release points, percent of the final ramp value
  localparam int MOB_CLAMP_LO_PCT = 75;
  localparam int MOB_CLAMP_HI_PCT = 88;

  // One register access from the serial engine
  typedef struct packed {
    logic       wr;      // Data byte written to addr
    logic       rd;      // Byte of addr being read
    logic       commit;  // End of a write transaction
    logic [7:0] addr;
    logic [7:0] data;
  } mob_reg_req_t;

  // Static configuration
  typedef struct packed {
    logic uc_mode;   // Microcontroller override mode
    logic pwr_thru;  // Power-on pin feeds the debounce logic
    logic ac_thru;   // AC sense feeds the AC-good function
    logic clamp_hi;  // Release clamp at the higher point
  } mob_cfg_t;

endpackage

// ---- mob_uc_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Supervisory microcontroller issuing register accesses
module mob_uc_model (
  input  wire logic                  i_clk,
  input  wire logic [7:0]            i_rd_data,
  output var  mob_pkg::mob_reg_req_t o_req
);
  import mob_pkg::*;

  logic pwr_seen;

  initial begin
    o_req = '0;
    pwr_seen = 1'b0;
  end

  // One request cycle: k is {wr, rd, commit}
  task automatic put(input logic [2:0] k, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_req = {k, a, d};
    @(posedge i_clk);
    #1;
    o_req = '0;
  endtask

  // Poll the request bit, broadcast a change with AC kept good
  task automatic poll;
    logic now;
    put(3'b010, MOB_OFS_READBACK, 8'h00);
    now = i_rd_data[MOB_BIT_PWR_RB];
    if (now !== pwr_seen) begin
      pwr_seen = now;
      put(3'b100, MOB_OFS_PWR_AC, {2'b00, 1'b1, 3'b000, now, 1'b0});
      put(3'b001, 8'h00, 8'h00);
    end
  endtask
endmodule

`default_nettype wire

// ---- microcontroller_override_bits_test.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, exp, got); \
  end end

module microcontroller_override_bits_test;
  import mob_pkg::*;

  logic         i_clk, i_rst, pwr, ac, pdb, agf, agr, power_enable_gate, clr, fp, ao, aoe;
  logic [7:0]   ramp, fin, flt, rdd;
  mob_cfg_t     cfg;
  mob_reg_req_t req;
  int           err_total = 0;
  int           checks = 0;
  logic [2:0]   tab [4];
  logic [7:0]   tr  [4];

  mob_uc_model mob_uc_model_i (.i_clk(i_clk), .i_rd_data(rdd), .o_req(req));

  mob_override mob_override_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_cfg(cfg),
    .i_pwr_req(pwr), .i_ac_sense(ac), .i_ramp(ramp), .i_ramp_final(fin),
    .i_fault_now(flt), .o_rd_data(rdd), .o_pwr_to_debounce(pdb),
    .o_ac_good_function(agf), .o_ac_good_report(agr),
    .o_power_enable_gate(power_enable_gate), .o_clamp_release(clr), .o_fault_pin(fp),
    .o_alert_o(ao), .o_alert_oe_n(aoe));

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
    end
  endtask

  // Write then commit, or read one byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mob_uc_model_i.put(3'b100, a, d);
    mob_uc_model_i.put(3'b001, 8'h00, 8'h00);
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a);
    mob_uc_model_i.put(3'b010, a, 8'h00);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  // Main sequence
  initial begin
    i_rst = 1'b1;
    cfg = '0;
    {pwr, ac} = 2'b00;
    {ramp, fin, flt} = {8'h00, 8'h64, 8'h00};
    tick(2);
    i_rst = 1'b0;
    `CHK("alert_oe_n", 1'b1, aoe)
    `CHK("gate", 1'b0, power_enable_gate)
    pwr = 1'b1;
    rd(MOB_OFS_READBACK);
    `CHK("readback", 8'h40, rdd)
    {pwr, ac} = 2'b01;
    rd(MOB_OFS_READBACK);
    `CHK("readback", 8'h80, rdd)
    rd(MOB_OFS_PWR_AC);
    `CHK("wo read", 8'h00, rdd)
    pwr = 1'b1;
    tick(2);
    `CHK("pwr_dbn", 1'b0, pdb)
    `CHK("ac_fn", 1'b0, agf)
    cfg.ac_thru = 1'b1;
    tick(2);
    `CHK("ac_fn", 1'b1, agf)
    cfg.pwr_thru = 1'b1;
    tick(2);
    `CHK("pwr_dbn", 1'b1, pdb)
    // Supervised mode, microcontroller broadcasts the pin
    cfg = '0;
    cfg.uc_mode = 1'b1;
    ac = 1'b0;
    mob_uc_model_i.poll();
    tick(1);
    `CHK("pwr_dbn", 1'b1, pdb)
    `CHK("ac_rep", 1'b1, agr)
    `CHK("gate", 1'b1, power_enable_gate)
    pwr = 1'b0;
    mob_uc_model_i.poll();
    tick(1);
    `CHK("gate", 1'b0, power_enable_gate)
    mob_uc_model_i.put(3'b100, MOB_OFS_PWR_AC, 8'h02);
    tick(2);
    `CHK("pwr_dbn", 1'b0, pdb)
    mob_uc_model_i.put(3'b001, 8'h00, 8'h00);
    tick(1);
    `CHK("pwr_dbn", 1'b1, pdb)
    `CHK("ac_fn", 1'b0, agf)
    wr(MOB_OFS_CLAMP, 8'h04);
    `CHK("clamp", 1'b1, clr)
    wr(MOB_OFS_CLAMP, 8'h00);
    `CHK("clamp", 1'b0, clr)
    // Automatic clamp release points: {hi, expected}
    cfg.uc_mode = 1'b0;
    tab = '{3'b000, 3'b001, 3'b010, 3'b011};
    tr = '{8'h4a, 8'h4b, 8'h57, 8'h58};
    for (int k = 0; k < 4; k++) begin
      cfg.clamp_hi = tab[k][1];
      ramp = tr[k];
      tick(2);
      `CHK("clamp", tab[k][0], clr)
    end
    // Fault latch, alert and read clear
    flt = 8'h03;
    tick(1);
    `CHK("alert_oe_n", 1'b0, aoe)
    `CHK("fault_pin", 1'b1, fp)
    flt = 8'h02;
    rd(MOB_OFS_FAULTS);
    `CHK("faults", 8'h03, rdd)
    flt = 8'h00;
    rd(MOB_OFS_FAULTS);
    `CHK("faults", 8'h02, rdd)
    rd(MOB_OFS_FAULTS);
    `CHK("faults", 8'h00, rdd)
    tick(1);
    `CHK("alert_oe_n", 1'b1, aoe)
    `CHK("alert_o", 1'b0, ao)
    wr(MOB_OFS_ALERT, 8'h02);
    `CHK("fault_pin", 1'b1, fp)
    wr(MOB_OFS_ALERT, 8'h00);
    `CHK("fault_pin", 1'b0, fp)
    end_of_test();
  end
endmodule

`default_nettype wire
